/* src/fbt_regs.sv */
// Register bank: queue status, bus reset info and command packet words
// Summary of operation
// - Bits 00-07 of queue status show transmit queue free quadlets.
// - Writing 1 to bit 08 flushes the transmit queue.
// - Bit 09 shows the transmit write buffer holds no data.
// - Bit 10 shows the transmit queue is full.
// - Bits 11-15 load the acknowledge code of each transmitted packet.
// - Bit 16 copies the 33rd bit on every receive queue read.
// - Writing 1 to bit 17 flushes the receive queue.
// - Bit 18 shows the receive read buffer is empty.
// - Writing 1 to bit 19 flushes the status queue.
// - Bits 20-23 show status queue occupancy in quadlets.
// - Bits 24-31 show receive queue occupancy in quadlets.
// - Bus reset bit 00 sets only when all topology results are valid.
// - Bus reset bits 02-07 show the number of nodes found.
// - Bus reset bit 08 shows this node is root.
// - Bits 16-25 hold a writable bus number, forced to 3FF on option.
// - Bits 26-31 load the new node number after each bus reset.
// - All stored bank bits clear to zero at power-up; live status fields follow their inputs.
// - First command word holds bytes 1,0,3,2 from bit 00 upward.
// - Second command word holds bytes 5,4,7,6 from bit 00 upward.
// - Third command word holds bytes 9,8,11,10 from bit 00 upward.
// - Offsets 44h-48h do nothing; reads return zero.
// - Bit 00 is the most significant bit; lowest byte address is top.
// - Auto-command set runs all phases on start; clear runs data only.
// - The start output is the trigger delayed one cycle, so it clears one cycle after the trigger.
// - Exhausted retries load the timeout code and raise the ack interrupt.
`timescale 1ns/1ps
module fbt_regs import fbt_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,

   // Host register bus
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [7:0] host_rdata,

   // Transmit queue
   input wire logic [7:0] tx_fifo_free_quadlets,
   input wire logic tx_write_buffer_empty,
   input wire logic tx_fifo_full_flag,
   input wire logic tx_ack_valid,
   input wire logic [4:0] tx_ack_code,
   input wire logic tx_retry_exhausted,
   input wire logic tx_flush_done,
   output logic tx_fifo_flush,
   output logic tx_ack_interrupt,

   // Receive queue
   input wire logic rx_fifo_read,
   input wire logic rx_bit33,
   input wire logic rx_read_buffer_empty,
   input wire logic [7:0] rx_fifo_level,
   input wire logic rx_flush_done,
   output logic rx_fifo_flush,

   // Status queue
   input wire logic [3:0] status_queue_level,
   input wire logic status_flush_done,
   output logic status_queue_flush,

   // Topology after serial-bus reset
   input wire logic bus_reset,
   input wire logic topology_done,
   input wire logic [5:0] nodes_found_count,
   input wire logic root_node,
   input wire logic [5:0] node_number_in,
   input wire logic bus_id_option,

   // Disk sequencer
   input wire logic disk_sequence_trigger,
   input wire logic auto_command_phase,
   input wire logic [3:0] cmd_byte_sel,
   output logic disk_sequence_go,
   output logic seq_full_auto,
   output logic [7:0] cmd_packet_byte
);

   // ***************
   // State
   // ***************
   typedef struct packed {
      logic [7:0] rdata;
      logic [4:0] ack;
      logic ack_irq;
      logic extra;
      logic topo_valid;
      logic [5:0] nodes;
      logic root;
      logic [9:0] bus_num;
      logic [5:0] node_num;
      logic [2:0][31:0] cmd;
      logic go;
      logic full_auto;
      logic [7:0] cmd_byte;
   } fbt_state_t;

   fbt_state_t st_reg;
   fbt_state_t st_next;

   // ***************
   // Decode functions
   // ***************
   function automatic fbt_sel_t reg_decode(input logic [7:0] a);
      fbt_sel_t s;
      case (a[7:2])
         FIFO_STATUS_OFF[7:2]: begin
            s = SEL_FIFO;
         end
         BUS_RESET_INFO_OFF[7:2]: begin
            s = SEL_BUSRST;
         end
         CMD_WORD0_OFF[7:2]: begin
            s = SEL_CMD0;
         end
         CMD_WORD1_OFF[7:2]: begin
            s = SEL_CMD1;
         end
         CMD_WORD2_OFF[7:2]: begin
            s = SEL_CMD2;
         end
         default: begin
            s = SEL_NONE;
         end
      endcase
      return s;
   endfunction : reg_decode

   // ***************
   // Byte lanes: lane 0 is the lowest address and the top byte
   // ***************
   function automatic logic [7:0] lane_get(input logic [31:0] w, input logic [1:0] l);
      return w[8*(3-l) +: 8];
   endfunction : lane_get

   function automatic logic [31:0] lane_put(input logic [31:0] w, input logic [1:0] l,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = w;
      r[8*(3-l) +: 8] = d;
      return r;
   endfunction : lane_put

   // ***************
   // Register words
   // ***************
   fbt_sel_t sel;
   logic [31:0] fs_word;
   logic [31:0] br_word;
   logic [31:0] br_merged;
   logic [2:0] fl_busy;
   logic [2:0] fl_done;

   assign sel = reg_decode(host_addr);
   assign fl_done = {status_flush_done, rx_flush_done, tx_flush_done};

   always_comb begin
      fs_word = REG_RESET;
      fs_word[FS_TX_FREE_LSB +: 8] = tx_fifo_free_quadlets;
      fs_word[FS_TX_FLUSH_POS] = fl_busy[0];
      fs_word[FS_TX_WBE_POS] = tx_write_buffer_empty;
      fs_word[FS_TX_FULL_POS] = tx_fifo_full_flag;
      fs_word[FS_ACK_LSB +: 5] = st_reg.ack;
      fs_word[FS_EXTRA_POS] = st_reg.extra;
      fs_word[FS_RX_FLUSH_POS] = fl_busy[1];
      fs_word[FS_RX_RBE_POS] = rx_read_buffer_empty;
      fs_word[FS_SQ_FLUSH_POS] = fl_busy[2];
      fs_word[FS_SQ_LVL_LSB +: 4] = status_queue_level;
      fs_word[FS_RX_LVL_LSB +: 8] = rx_fifo_level;
   end

   always_comb begin
      br_word = REG_RESET;
      br_word[BR_VALID_POS] = st_reg.topo_valid;
      br_word[BR_NODES_LSB +: 6] = st_reg.nodes;
      br_word[BR_ROOT_POS] = st_reg.root;
      br_word[BR_BUS_LSB +: 10] = st_reg.bus_num;
      br_word[BR_NODE_LSB +: 6] = st_reg.node_num;
   end

   assign br_merged = lane_put(br_word, host_addr[1:0], host_wdata);

   // ***************
   // Queue flush controls
   // ***************
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_flush
         fbt_flush_if fl ();
         localparam int POS = FLUSH_POS[gi];
         localparam logic [1:0] LANE = 2'(3 - POS / 8);
         assign fl.start = host_wr && sel == SEL_FIFO && host_addr[1:0] == LANE
                           && host_wdata[POS % 8];
         assign fl.done = fl_done[gi];
         assign fl_busy[gi] = fl.busy;
         fbt_flush_ctl u_flush (
            .core_clk (core_clk),
            .nrst (nrst),
            .fl (fl.ctl)
         );
      end
   endgenerate

   assign tx_fifo_flush = fl_busy[0];
   assign rx_fifo_flush = fl_busy[1];
   assign status_queue_flush = fl_busy[2];

   // ***************
   // Next state
   // ***************
   always_comb begin
      logic [31:0] rd_word;
      logic [1:0] cw;
      logic [1:0] cl;
      rd_word = REG_RESET;
      cw = 2'(cmd_byte_sel / 4);
      cl = 2'(cmd_byte_sel % 4) ^ 2'h1;
      st_next = st_reg;

      // ***************
      // Host read; reserved and unmapped offsets read zero
      // ***************
      case (sel)
         SEL_FIFO: begin
            rd_word = fs_word;
         end
         SEL_BUSRST: begin
            rd_word = br_word;
         end
         SEL_CMD0: begin
            rd_word = st_reg.cmd[0];
         end
         SEL_CMD1: begin
            rd_word = st_reg.cmd[1];
         end
         SEL_CMD2: begin
            rd_word = st_reg.cmd[2];
         end
         default: begin
            rd_word = REG_RESET;
         end
      endcase
      if (host_rd) begin
         st_next.rdata = lane_get(rd_word, host_addr[1:0]);
      end

      // ***************
      // Host write to command words and bus info
      // ***************
      if (host_wr) begin
         case (sel)
            SEL_CMD0: begin
               st_next.cmd[0] = lane_put(st_reg.cmd[0], host_addr[1:0], host_wdata);
            end
            SEL_CMD1: begin
               st_next.cmd[1] = lane_put(st_reg.cmd[1], host_addr[1:0], host_wdata);
            end
            SEL_CMD2: begin
               st_next.cmd[2] = lane_put(st_reg.cmd[2], host_addr[1:0], host_wdata);
            end
            SEL_BUSRST: begin
               st_next.bus_num = br_merged[BR_BUS_LSB +: 10];
               st_next.node_num = br_merged[BR_NODE_LSB +: 6];
            end
            default: begin
               st_next.rdata = st_next.rdata;
            end
         endcase
      end

      // ***************
      // Acknowledge capture and interrupt
      // ***************
      st_next.ack_irq = 1'b0;
      if (tx_ack_valid) begin
         st_next.ack = tx_ack_code;
         st_next.ack_irq = 1'b1;
      end
      if (tx_retry_exhausted) begin
         st_next.ack = ACK_TIMEOUT_CODE;
         st_next.ack_irq = 1'b1;
      end

      // ***************
      // Extra receive bit
      // ***************
      if (rx_fifo_read) begin
         st_next.extra = rx_bit33;
      end

      // ***************
      // Topology results; hardware update beats a host write
      // ***************
      if (bus_reset) begin
         st_next.topo_valid = 1'b0;
         if (bus_id_option) begin
            st_next.bus_num = BUS_NUM_FORCED;
         end
      end
      if (topology_done) begin
         st_next.topo_valid = 1'b1;
         st_next.nodes = nodes_found_count;
         st_next.root = root_node;
         st_next.node_num = node_number_in;
      end

      // ***************
      // Disk sequence start, the trigger delayed by one cycle
      // ***************
      st_next.go = disk_sequence_trigger;
      if (disk_sequence_trigger) begin
         st_next.full_auto = auto_command_phase;
      end

      // ***************
      // Command byte presented to the sequencer
      // ***************
      st_next.cmd_byte = 8'h00;
      if (cmd_byte_sel < 4'(CMD_BYTES)) begin
         st_next.cmd_byte = lane_get(st_reg.cmd[cw], cl);
      end
   end

   // ***************
   // State register
   // ***************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***************
   // Outputs
   // ***************
   assign host_rdata = st_reg.rdata;
   assign tx_ack_interrupt = st_reg.ack_irq;
   assign disk_sequence_go = st_reg.go;
   assign seq_full_auto = st_reg.full_auto;
   assign cmd_packet_byte = st_reg.cmd_byte;

endmodule : fbt_regs

/* src/fbt_pkg.sv */
// Package: offsets, field positions and reset values of the register bank
package fbt_pkg;

   // ***************
   // Register offsets
   // ***************
   localparam logic [7:0] FIFO_STATUS_OFF = 8'h30;
   localparam logic [7:0] BUS_RESET_INFO_OFF = 8'h34;
   localparam logic [7:0] CMD_WORD0_OFF = 8'h38;
   localparam logic [7:0] CMD_WORD1_OFF = 8'h3C;
   localparam logic [7:0] CMD_WORD2_OFF = 8'h40;
   localparam logic [7:0] RESERVED_A_OFF = 8'h44;
   localparam logic [7:0] RESERVED_B_OFF = 8'h48;

   // ***************
   // FIFO status fields (vector bit = 31 - printed bit)
   // ***************
   localparam int FS_TX_FREE_LSB = 24;
   localparam int FS_TX_FLUSH_POS = 23;
   localparam int FS_TX_WBE_POS = 22;
   localparam int FS_TX_FULL_POS = 21;
   localparam int FS_ACK_LSB = 16;
   localparam int FS_EXTRA_POS = 15;
   localparam int FS_RX_FLUSH_POS = 14;
   localparam int FS_RX_RBE_POS = 13;
   localparam int FS_SQ_FLUSH_POS = 12;
   localparam int FS_SQ_LVL_LSB = 8;
   localparam int FS_RX_LVL_LSB = 0;
   localparam int FLUSH_POS [3] = '{FS_TX_FLUSH_POS, FS_RX_FLUSH_POS, FS_SQ_FLUSH_POS};

   // ***************
   // Bus reset info fields
   // ***************
   localparam int BR_VALID_POS = 31;
   localparam int BR_NODES_LSB = 24;
   localparam int BR_ROOT_POS = 23;
   localparam int BR_BUS_LSB = 6;
   localparam int BR_NODE_LSB = 0;

   // ***************
   // Reset and forced values
   // ***************
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [9:0] BUS_NUM_FORCED = 10'h3FF;
   localparam logic [4:0] ACK_TIMEOUT_CODE = 5'h1F;
   localparam int CMD_BYTES = 12;

   typedef enum logic [2:0] {
      SEL_FIFO, SEL_BUSRST, SEL_CMD0, SEL_CMD1, SEL_CMD2, SEL_NONE
   } fbt_sel_t;

endpackage : fbt_pkg

/* src/fbt_flush_if.sv */
// Interface: start, done and busy of one queue flush
`timescale 1ns/1ps
interface fbt_flush_if;
   logic start;
   logic done;
   logic busy;
   modport ctl (input start, input done, output busy);
   modport host (output start, output done, input busy);
endinterface : fbt_flush_if

/* src/fbt_flush_ctl.sv */
// Self-clearing flush control for one queue
`timescale 1ns/1ps
module fbt_flush_ctl import fbt_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Flush handshake
   fbt_flush_if.ctl fl
);

   typedef struct packed {
      logic busy;
   } fbt_flush_state_t;

   fbt_flush_state_t st_reg;
   fbt_flush_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (fl.done) begin
         st_next.busy = 1'b0;
      end
      if (fl.start) begin
         st_next.busy = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fl.busy = st_reg.busy;

endmodule : fbt_flush_ctl

/* tb/fbt_regs_props.sv */
// Checker: port timing relations of the register bank
`timescale 1ns/1ps
module fbt_regs_props import fbt_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Host bus
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_rdata,
   // Queues
   input wire logic [7:0] tx_fifo_free_quadlets,
   input wire logic [7:0] rx_fifo_level,
   input wire logic tx_flush_done,
   input wire logic tx_fifo_flush,
   input wire logic rx_fifo_flush,
   input wire logic status_queue_flush,
   input wire logic tx_ack_valid,
   input wire logic tx_retry_exhausted,
   input wire logic tx_ack_interrupt,
   // Sequencer
   input wire logic disk_sequence_trigger,
   input wire logic auto_command_phase,
   input wire logic disk_sequence_go,
   input wire logic seq_full_auto
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire logic tx_set = host_wr && host_addr == 8'h31 && host_wdata[7];
   // ********
   // Properties
   // ********
   a_tx_flush_set: assert property (tx_set |=> tx_fifo_flush)
      else $error("tx flush not raised");
   a_rx_flush_set: assert property (host_wr && host_addr == 8'h32 && host_wdata[6]
      |=> rx_fifo_flush) else $error("rx flush not raised");
   a_sq_flush_set: assert property (host_wr && host_addr == 8'h32 && host_wdata[4]
      |=> status_queue_flush) else $error("status flush not raised");
   a_flush_self_clear: assert property (tx_fifo_flush && tx_flush_done && !tx_set
      |=> !tx_fifo_flush) else $error("tx flush stuck");
   a_read_free: assert property (host_rd && host_addr == 8'h30
      |=> host_rdata == $past(tx_fifo_free_quadlets)) else $error("free count wrong");
   a_read_rx_level: assert property (host_rd && host_addr == 8'h33
      |=> host_rdata == $past(rx_fifo_level)) else $error("rx level wrong");
   a_reserved_zero: assert property (host_rd && host_addr inside {[8'h44:8'h4B]}
      |=> host_rdata == 8'h00) else $error("reserved read not zero");
   a_ack_irq: assert property ((tx_ack_valid || tx_retry_exhausted)
      |=> tx_ack_interrupt) else $error("ack interrupt missing");
   a_go_cause: assert property (disk_sequence_go |-> $past(disk_sequence_trigger))
      else $error("go without trigger");
   a_go_mode: assert property (disk_sequence_trigger
      |=> disk_sequence_go && seq_full_auto == $past(auto_command_phase))
      else $error("sequencer mode wrong");
   cover property (disk_sequence_trigger && auto_command_phase);
   cover property (tx_fifo_flush && tx_flush_done);
   cover property (tx_retry_exhausted);
endmodule : fbt_regs_props

/* tb/fbt_host_model.sv */
// Host model: embedded processor byte accesses
`timescale 1ns/1ps
module fbt_host_model (
   // Clock
   input wire logic core_clk,
   // Host bus
   output logic [7:0] host_addr,
   output logic [7:0] host_wdata,
   output logic host_wr,
   output logic host_rd,
   input wire logic [7:0] host_rdata
);
   initial begin
      host_addr = 8'h00;
      host_wdata = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
   end
   // One-cycle strobes; idle bus shows inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge core_clk);
      host_wr = 1'b0;
      host_addr = ~a;
      host_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge core_clk);
      host_rd = 1'b0;
      host_addr = ~a;
      d = host_rdata;
   endtask : rd
endmodule : fbt_host_model

/* tb/fbt_regs_tb.sv */
// Testbench: register bank table cases and event cases
`timescale 1ns/1ps
module fbt_regs_tb;
   import fbt_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] e;} fbt_row_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] host_addr, host_wdata, host_rdata, cmd_packet_byte, d;
   logic host_wr, host_rd, tx_fifo_flush, tx_ack_interrupt, rx_fifo_flush, status_queue_flush;
   logic disk_sequence_go, seq_full_auto;
   logic [7:0] tx_fifo_free_quadlets = 8'h5A, rx_fifo_level = 8'hC3;
   logic tx_write_buffer_empty = 1'b1, rx_read_buffer_empty = 1'b1, tx_fifo_full_flag = 1'b0;
   logic tx_ack_valid = 1'b0, tx_retry_exhausted = 1'b0, rx_fifo_read = 1'b0, rx_bit33 = 1'b0;
   logic bus_reset = 1'b0, topology_done = 1'b0, root_node = 1'b0, bus_id_option = 1'b0;
   logic disk_sequence_trigger = 1'b0, auto_command_phase = 1'b0;
   logic [4:0] tx_ack_code = 5'h00;
   logic [3:0] status_queue_level = 4'h9, cmd_byte_sel = 4'h0;
   logic [5:0] nodes_found_count = 6'h00, node_number_in = 6'h00;
   logic [2:0] done_v = 3'h0;
   wire logic tx_flush_done = done_v[0];
   wire logic rx_flush_done = done_v[1];
   wire logic status_flush_done = done_v[2];
   wire logic [2:0] fl_now = {status_queue_flush, rx_fifo_flush, tx_fifo_flush};
   int n_fail = 0;
   int cmp_count = 0;
   fbt_row_t rows [8] = '{'{8'h30, 8'h5A}, '{8'h31, 8'h40}, '{8'h32, 8'h29}, '{8'h33, 8'hC3},
      '{8'h34, 8'h00}, '{8'h38, 8'h00}, '{8'h44, 8'h00}, '{8'h4B, 8'h00}};
   logic [7:0] fa [3] = '{8'h31, 8'h32, 8'h32};
   logic [7:0] fd [3] = '{8'h80, 8'h40, 8'h10};
   logic [7:0] fe [3] = '{8'hC0, 8'h69, 8'h39};
   fbt_regs dut_u (.*);
   fbt_host_model host_u (.*);
   // ********
   // Checking tasks
   // ********
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      host_u.rd(a, v);
      chk($sformatf("byte %h", a), e, v);
   endtask : rchk
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask : pulse
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   // ********
   // Clock, watchdog and sequence
   // ********
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      #200us;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      host_u.wr(8'h30, 8'hFF);
      host_u.wr(8'h44, 8'hFF);
      foreach (rows[i]) begin
         rchk(rows[i].a, rows[i].e);
      end
      for (int k = 0; k < 12; k++) begin
         host_u.wr(8'h38 + 8'(k), 8'hA0 + 8'(k));
      end
      for (int k = 0; k < 13; k++) begin
         if (k < 12) begin
            rchk(8'h38 + 8'(k), 8'hA0 + 8'(k));
         end
         cmd_byte_sel = 4'(k);
         @(negedge core_clk);
         chk("cmd byte", (k < 12) ? 8'hA0 + 8'(k ^ 1) : 8'h00, cmd_packet_byte);
      end
      for (int i = 0; i < 3; i++) begin
         host_u.wr(fa[i], fd[i]);
         chk("flush set", 8'h01 << i, {5'h00, fl_now});
         rchk(fa[i], fe[i]);
         done_v = 3'(1 << i);
         @(negedge core_clk);
         done_v = 3'h0;
         chk("flush clear", 8'h00, {5'h00, fl_now});
      end
      tx_fifo_full_flag = 1'b1;
      tx_ack_code = 5'h0B;
      pulse(tx_ack_valid);
      chk("ack irq", 8'h01, {7'h00, tx_ack_interrupt});
      rchk(8'h31, 8'h6B);
      pulse(tx_retry_exhausted);
      rchk(8'h31, 8'h7F);
      rx_bit33 = 1'b1;
      pulse(rx_fifo_read);
      rx_bit33 = 1'b0;
      rchk(8'h32, 8'hA9);
      tx_fifo_full_flag = 1'b0;
      tx_write_buffer_empty = 1'b0;
      rx_read_buffer_empty = 1'b0;
      rchk(8'h31, 8'h1F);
      pulse(rx_fifo_read);
      rchk(8'h32, 8'h09);
      nodes_found_count = 6'h2A;
      root_node = 1'b1;
      node_number_in = 6'h15;
      pulse(topology_done);
      rchk(8'h34, 8'hAA);
      rchk(8'h35, 8'h80);
      rchk(8'h37, 8'h15);
      bus_id_option = 1'b1;
      pulse(bus_reset);
      host_u.rd(8'h34, d);
      chk("valid after reset", 8'h00, d & 8'h80);
      rchk(8'h36, 8'hFF);
      host_u.wr(8'h36, 8'h12);
      rchk(8'h36, 8'h12);
      rchk(8'h37, 8'hD5);
      fork
         host_u.wr(8'h31, 8'h80);
         begin
            @(negedge core_clk);
            done_v = 3'h1;
            @(negedge core_clk);
            done_v = 3'h0;
         end
      join
      chk("flush set wins", 8'h01, {5'h00, fl_now});
      done_v = 3'h1;
      @(negedge core_clk);
      done_v = 3'h0;
      chk("flush clear", 8'h00, {5'h00, fl_now});
      for (int i = 0; i < 2; i++) begin
         auto_command_phase = 1'(i);
         pulse(disk_sequence_trigger);
         chk("go", 8'h01, {7'h00, disk_sequence_go});
         chk("auto", 8'(i), {7'h00, seq_full_auto});
         @(negedge core_clk);
         chk("go off", 8'h00, {7'h00, disk_sequence_go});
      end
      nrst = 1'b0;
      @(negedge core_clk);
      nrst = 1'b1;
      rchk(8'h38, 8'h00);
      rchk(8'h36, 8'h00);
      rchk(8'h31, 8'h00);
      stop_test();
   end
endmodule : fbt_regs_tb
bind fbt_regs fbt_regs_props chk_u (.*);
